// >>> hdl/i2csr_pkg.sv
// Constants and carrier types for the two-wire register slave port
package i2csr_pkg;

    // Fixed upper six bits of the 7-bit slave address (binary 110100)
    localparam logic [5:0] DEV_ADDR_HI = 6'h34;

    // Byte and slot layout; bit counts are bits seen since the slot began
    localparam int BYTE_W = 8;
    localparam logic [3:0] CNT_FIRST = 4'h1;
    localparam logic [3:0] CNT_AFTER_START = 4'h2;
    localparam logic [3:0] CNT_LAST_DATA = 4'h8;
    localparam logic [3:0] CNT_ACK_SLOT = 4'h9;

    // Position of the direction bit in the address byte
    localparam int DIR_BIT = 0;

    // Register pointer value after reset
    localparam logic [7:0] PTR_RESET = 8'h00;

    // Bus timeout: clock held low this long drops the frame and frees the data line
    localparam int unsigned SYS_CLK_HZ = 125_000_000;
    localparam int unsigned MS_PER_S = 1000;
    localparam int unsigned TIMEOUT_MS = 35;
    localparam int unsigned TIMEOUT_CYC = SYS_CLK_HZ / MS_PER_S * TIMEOUT_MS;
    localparam int TIMEOUT_W = 23;

    // Bit positions in the system-side synchroniser bank
    localparam int SYNC_W = 6;
    localparam int SY_SCL = 0;
    localparam int SY_SDA = 1;
    localparam int SY_ADSEL = 2;
    localparam int SY_EVT = 3;
    localparam int SY_DRV = 4;
    localparam int SY_SEEN = 5;
    localparam logic [SYNC_W-1:0] SYNC_RESET = 6'h03;

    // Phase of the link engine within a transfer
    typedef enum logic [2:0] {
        PH_IDLE = 3'b000,
        PH_ADDR = 3'b001,
        PH_PTR = 3'b010,
        PH_WDATA = 3'b011,
        PH_RDATA = 3'b100
    } i2csr_phase_e;

    // Byte events handed from the link domain to the system domain
    typedef enum logic [1:0] {
        EV_PTR = 2'b00,
        EV_WRITE = 2'b01,
        EV_READ = 2'b10
    } i2csr_evt_e;

    typedef struct packed {
        i2csr_evt_e kind;
        logic [7:0] data;
    } i2csr_evt_s;

    // Register access request toward the register file
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wrData;
        logic wrEn;
        logic rdEn;
    } i2csr_regreq_s;

    // Link state sampled on the rising serial clock
    typedef struct packed {
        i2csr_phase_e phase;
        logic [3:0] cnt;
        logic [7:0] shift;
        i2csr_evt_s evt;
        logic evtTgl;
        logic seenTgl;
        logic startS2;
    } i2csr_link_s;

    // Link state updated on the falling serial clock
    typedef struct packed {
        logic startS1;
        logic drvLow;
        logic [7:0] txSh;
    } i2csr_drive_s;

    // System clock domain state
    typedef struct packed {
        logic sclPrev;
        logic sdaPrev;
        logic frameActive;
        logic startTgl;
        logic evtSeen;
        logic rdPend;
        logic [7:0] ptr;
        logic [7:0] rdByte;
        logic [TIMEOUT_W-1:0] toCnt;
        i2csr_regreq_s req;
        logic sdaOe;
        logic sdaOut;
    } i2csr_sys_s;

endpackage

// >>> hdl/i2csr_sync.sv
// Two-flop synchroniser bank with per-bit reset values
`timescale 1ns/100ps
module i2csr_sync #(
    parameter int WIDTH = 1,
    parameter logic [WIDTH-1:0] RST_VAL = '0
) (
    input wire logic clk,
    input wire logic rst_n,
    input wire logic [WIDTH-1:0] asyncIn,
    output logic [WIDTH-1:0] syncOut
);

    logic [WIDTH-1:0] meta_q;

    // First stage feeds only the second stage
    always_ff @(posedge clk or negedge rst_n) begin
        if (!rst_n) begin
            meta_q <= RST_VAL;
            syncOut <= RST_VAL;
        end else begin
            meta_q <= asyncIn;
            syncOut <= meta_q;
        end
    end

endmodule // i2csr_sync

// >>> hdl/i2csr_slave.sv
// Two-wire slave port giving a bus master byte access to internal registers
`timescale 1ns/100ps

module i2csr_slave #(
    parameter int unsigned TIMEOUT_CYCLES = i2csr_pkg::TIMEOUT_CYC
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclClk,
    input wire logic sdaIn,
    output logic sdaOut,
    output logic sdaOe,
    input wire logic addressSelectPin,
    output i2csr_pkg::i2csr_regreq_s regReq,
    input wire logic [7:0] regRdData
);

    // Last count of the timeout counter before it declares the bus stuck.
    // The default is sized for the full stuck-clock period; benches pass a
    // small value so the release can be seen in a short run. A master that
    // stretches the clock low for longer than this loses its frame.
    localparam logic [i2csr_pkg::TIMEOUT_W-1:0] TO_LAST =
        i2csr_pkg::TIMEOUT_W'(TIMEOUT_CYCLES - 1);

    // State lives in three regions: the system clock, the rising serial
    // clock (bit sampling, byte decode) and the falling serial clock (data
    // line changes). Each region owns one struct and nothing else writes it.
    // Only toggles and settled fields cross between regions; the fields a
    // toggle announces are stable before the toggle itself moves.
    i2csr_pkg::i2csr_link_s lnk_q;
    i2csr_pkg::i2csr_link_s lnk_d;
    i2csr_pkg::i2csr_drive_s drv_q;
    i2csr_pkg::i2csr_drive_s drv_d;
    i2csr_pkg::i2csr_sys_s sys_q;
    i2csr_pkg::i2csr_sys_s sys_d;

    logic [i2csr_pkg::SYNC_W-1:0] syncIn;
    logic [i2csr_pkg::SYNC_W-1:0] syncOut;
    logic sclS;
    logic sdaS;
    logic adSelS;
    logic evtS;
    logic drvS;
    logic seenS;
    logic startDet;
    logic stopDet;

    // Address byte match: fixed upper bits plus the strap level.
    // Used both when deciding to acknowledge and when decoding the byte,
    // so the two can never disagree about a match.
    function automatic logic addrMatch(input logic [7:0] b, input logic sel);
        return b[7:1] == {i2csr_pkg::DEV_ADDR_HI, sel};
    endfunction

    // ------------------------------------------------------------------
    // System domain: pin sampling, frame tracking, register access
    // ------------------------------------------------------------------

    // Everything the system clock reads from pins or the link domain, except the event fields.
    // One bank keeps all these samples aligned to the same two-flop delay,
    // which the START/STOP detector relies on: clock and data must be seen
    // with equal lag or a data edge near a clock edge looks like a condition.
    assign syncIn = {lnk_q.seenTgl, drv_q.drvLow, lnk_q.evtTgl,
                     addressSelectPin, sdaIn, sclClk};

    i2csr_sync #(
        .WIDTH(i2csr_pkg::SYNC_W),
        .RST_VAL(i2csr_pkg::SYNC_RESET)
    ) u_sync (
        .clk(clk_sys),
        .rst_n(rst_n),
        .asyncIn(syncIn),
        .syncOut(syncOut)
    );

    // Named views of the synchronised bank
    assign sclS = syncOut[i2csr_pkg::SY_SCL];
    assign sdaS = syncOut[i2csr_pkg::SY_SDA];
    assign adSelS = syncOut[i2csr_pkg::SY_ADSEL];
    assign evtS = syncOut[i2csr_pkg::SY_EVT];
    assign drvS = syncOut[i2csr_pkg::SY_DRV];
    assign seenS = syncOut[i2csr_pkg::SY_SEEN];

    // Bus conditions: data edges while the clock stays high.
    // Both samples of the clock must be high, so a data change that races a
    // clock edge by less than one system cycle is not taken as a condition.
    assign startDet = sclS & sys_q.sclPrev & sys_q.sdaPrev & ~sdaS;
    assign stopDet = sclS & sys_q.sclPrev & ~sys_q.sdaPrev & sdaS;

    // System next state
    always_comb begin
        sys_d = sys_q;
        sys_d.sclPrev = sclS;
        sys_d.sdaPrev = sdaS;
        sys_d.req.wrEn = 1'b0;
        sys_d.req.rdEn = 1'b0;
        sys_d.sdaOut = 1'b0;

        // A repeated START also restarts the frame and realigns the link
        if (startDet) begin
            sys_d.startTgl = ~sys_q.startTgl;
            sys_d.frameActive = 1'b1;
        end else if (stopDet) begin
            sys_d.frameActive = 1'b0;
        end

        // Stuck-low clock detection; relies on this clock running.
        // The counter saturates so the frame stays dropped until a START;
        // the link engine itself is not reset here, it realigns at the START.
        if (sclS) begin
            sys_d.toCnt = '0;
        end else if (sys_q.toCnt != TO_LAST) begin
            sys_d.toCnt = sys_q.toCnt + 1'b1;
        end else begin
            sys_d.frameActive = 1'b0;
        end

        // Byte events; the event fields were stable before the toggle moved
        if (evtS != sys_q.evtSeen) begin
            sys_d.evtSeen = evtS;
            unique case (lnk_q.evt.kind)
                i2csr_pkg::EV_PTR: begin
                    sys_d.ptr = lnk_q.evt.data;
                end
                i2csr_pkg::EV_WRITE: begin
                    sys_d.req.addr = sys_q.ptr;
                    sys_d.req.wrData = lnk_q.evt.data;
                    sys_d.req.wrEn = 1'b1;
                    sys_d.ptr = sys_q.ptr + 1'b1;
                end
                i2csr_pkg::EV_READ: begin
                    sys_d.req.addr = sys_q.ptr;
                    sys_d.req.rdEn = 1'b1;
                    sys_d.rdPend = 1'b1;
                    sys_d.ptr = sys_q.ptr + 1'b1;
                end
                default: begin
                end
            endcase
        end

        // Read data arrives one cycle after the strobe.
        // The byte is held until the next fetch; the falling-edge stage
        // copies it at the end of the acknowledge slot, long after it settled.
        if (sys_q.rdPend) begin
            sys_d.rdByte = regRdData;
            sys_d.rdPend = 1'b0;
        end

        // Drive only inside a live frame the link has already realigned to;
        // a stale low from an aborted transfer can never hold the bus
        sys_d.sdaOe = drvS & sys_q.frameActive & (seenS == sys_q.startTgl);
    end

    // System state register.
    // Edge history resets to the idle-high bus level so no false START or
    // STOP is seen in the first cycles after reset.
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            sys_q <= '{
                sclPrev: 1'b1,
                sdaPrev: 1'b1,
                frameActive: 1'b0,
                startTgl: 1'b0,
                evtSeen: 1'b0,
                rdPend: 1'b0,
                ptr: i2csr_pkg::PTR_RESET,
                rdByte: 8'h00,
                toCnt: '0,
                req: '0,
                sdaOe: 1'b0,
                sdaOut: 1'b0
            };
        end else begin
            sys_q <= sys_d;
        end
    end

    // ------------------------------------------------------------------
    // Link domain, rising serial clock: sample bits, decode bytes
    // ------------------------------------------------------------------

    // The START toggle reaches this edge through the falling-edge stage,
    // so a START is seen one bit late; the first address bit is already
    // in the shifter by then, hence the count restarts at two
    always_comb begin
        lnk_d = lnk_q;
        lnk_d.startS2 = drv_q.startS1;
        lnk_d.shift = {lnk_q.shift[6:0], sdaIn};
        if (lnk_q.startS2 != lnk_q.seenTgl) begin
            lnk_d.seenTgl = lnk_q.startS2;
            lnk_d.phase = i2csr_pkg::PH_ADDR;
            lnk_d.cnt = i2csr_pkg::CNT_AFTER_START;
        end else if (lnk_q.cnt == i2csr_pkg::CNT_ACK_SLOT) begin
            lnk_d.cnt = i2csr_pkg::CNT_FIRST;
        end else if (lnk_q.cnt == i2csr_pkg::CNT_LAST_DATA) begin
            // This edge samples the acknowledge slot; shift holds the byte
            lnk_d.cnt = i2csr_pkg::CNT_ACK_SLOT;
            lnk_d.evt.data = lnk_q.shift;
            unique case (lnk_q.phase)
                i2csr_pkg::PH_ADDR: begin
                    if (!addrMatch(lnk_q.shift, adSelS)) begin
                        lnk_d.phase = i2csr_pkg::PH_IDLE;
                    end else if (lnk_q.shift[i2csr_pkg::DIR_BIT]) begin
                        lnk_d.phase = i2csr_pkg::PH_RDATA;
                        lnk_d.evt.kind = i2csr_pkg::EV_READ;
                        lnk_d.evtTgl = ~lnk_q.evtTgl;
                    end else begin
                        lnk_d.phase = i2csr_pkg::PH_PTR;
                    end
                end
                i2csr_pkg::PH_PTR: begin
                    lnk_d.phase = i2csr_pkg::PH_WDATA;
                    lnk_d.evt.kind = i2csr_pkg::EV_PTR;
                    lnk_d.evtTgl = ~lnk_q.evtTgl;
                end
                i2csr_pkg::PH_WDATA: begin
                    lnk_d.evt.kind = i2csr_pkg::EV_WRITE;
                    lnk_d.evtTgl = ~lnk_q.evtTgl;
                end
                i2csr_pkg::PH_RDATA: begin
                    // Master acknowledge asks for the next byte
                    if (!sdaIn) begin
                        lnk_d.evt.kind = i2csr_pkg::EV_READ;
                        lnk_d.evtTgl = ~lnk_q.evtTgl;
                    end else begin
                        lnk_d.phase = i2csr_pkg::PH_IDLE;
                    end
                end
                i2csr_pkg::PH_IDLE: begin
                end
                default: begin
                    lnk_d.phase = i2csr_pkg::PH_IDLE;
                end
            endcase
        end else begin
            lnk_d.cnt = lnk_q.cnt + 1'b1;
        end
    end

    // Rising-edge link register.
    // Only runs while the master clocks; a stalled bus leaves it frozen,
    // which is why the system side gates the drive with the frame state.
    always_ff @(posedge sclClk or negedge rst_n) begin
        if (!rst_n) begin
            lnk_q <= '{
                phase: i2csr_pkg::PH_IDLE,
                cnt: 4'h0,
                shift: 8'h00,
                evt: '{kind: i2csr_pkg::EV_PTR, data: 8'h00},
                evtTgl: 1'b0,
                seenTgl: 1'b0,
                startS2: 1'b0
            };
        end else begin
            lnk_q <= lnk_d;
        end
    end

    // ------------------------------------------------------------------
    // Link domain, falling serial clock: change the data line while low
    // ------------------------------------------------------------------

    // Decisions use the byte state settled on the preceding rising edge.
    // Changing the line only on the falling edge keeps data stable while the
    // clock is high; the system-side flops add a few cycles of hold after it.
    always_comb begin
        drv_d = drv_q;
        drv_d.startS1 = sys_q.startTgl;
        drv_d.drvLow = 1'b0;
        if (lnk_q.cnt == i2csr_pkg::CNT_LAST_DATA) begin
            unique case (lnk_q.phase)
                i2csr_pkg::PH_ADDR: begin
                    drv_d.drvLow = addrMatch(lnk_q.shift, adSelS);
                end
                i2csr_pkg::PH_PTR, i2csr_pkg::PH_WDATA: begin
                    drv_d.drvLow = 1'b1;
                end
                i2csr_pkg::PH_IDLE, i2csr_pkg::PH_RDATA: begin
                    drv_d.drvLow = 1'b0;
                end
                default: begin
                    drv_d.drvLow = 1'b0;
                end
            endcase
        end else if (lnk_q.phase == i2csr_pkg::PH_RDATA) begin
            // Read byte fetched by the system side during the clock high time
            if (lnk_q.cnt == i2csr_pkg::CNT_ACK_SLOT) begin
                drv_d.txSh = sys_q.rdByte;
                drv_d.drvLow = ~sys_q.rdByte[7];
            end else begin
                drv_d.txSh = {drv_q.txSh[6:0], 1'b0};
                drv_d.drvLow = ~drv_q.txSh[6];
            end
        end
    end

    // Falling-edge link register.
    // Also carries the first stage of the START toggle into the link region;
    // the rising edge takes the second stage, half a serial period later.
    always_ff @(negedge sclClk or negedge rst_n) begin
        if (!rst_n) begin
            drv_q <= '{startS1: 1'b0, drvLow: 1'b0, txSh: 8'h00};
        end else begin
            drv_q <= drv_d;
        end
    end

    // Outputs straight from system-domain flops.
    // The line is open drain: the level is always low and only the enable
    // moves, so the port can never fight the pull-up or another driver.
    assign sdaOe = sys_q.sdaOe;
    assign sdaOut = sys_q.sdaOut;
    assign regReq = sys_q.req;

endmodule // i2csr_slave

// >>> verif/i2csr_monitor.sv
// Assertion checker for the two-wire register slave port
`timescale 1ns/100ps
module i2csr_monitor #(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    input wire logic clk_sys,
    input wire logic rst_n,
    input wire logic sclClk,
    input wire logic sdaIn,
    input wire logic sdaOut,
    input wire logic sdaOe,
    input wire logic addressSelectPin,
    input wire i2csr_pkg::i2csr_regreq_s regReq,
    input wire logic [7:0] regRdData
);
    default clocking cb @(posedge clk_sys);
    endclocking
    default disable iff (!rst_n);

    logic [31:0] lowCnt_q;
    logic req;

    // Cycles spent with the serial clock low, cleared on any high sample
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            lowCnt_q <= '0;
        end else begin
            lowCnt_q <= sclClk ? '0 : lowCnt_q + 32'h1;
        end
    end

    assign req = regReq.wrEn | regReq.rdEn;

    // Register strobes are at least nine system cycles apart
    sequence s_quiet;
        !req [*8];
    endsequence

    property p_drain; sdaOut == 1'b0; endproperty
    a_drain: assert property (p_drain) else $error("data line driven high");
    property p_spacing; req |=> s_quiet; endproperty
    a_spacing: assert property (p_spacing) else $error("strobes too close");
    property p_excl; !(regReq.wrEn && regReq.rdEn); endproperty
    a_excl: assert property (p_excl) else $error("write and fetch together");
    property p_reqScl; req |-> sclClk; endproperty
    a_reqScl: assert property (p_reqScl) else $error("strobe outside clock high");
    property p_timeout; lowCnt_q == TIMEOUT_CYCLES + 8 |-> !sdaOe; endproperty
    a_timeout: assert property (p_timeout) else $error("line held past timeout");
    property p_oeLow; $changed(sdaOe) |-> !sclClk; endproperty
    a_oeLow: assert property (p_oeLow) else $error("drive changed with clock high");
    property p_hold; $rose(sclClk) |-> $stable(sdaOe) [*8]; endproperty
    a_hold: assert property (p_hold) else $error("driven bit not held");
    property p_reset; $rose(rst_n) |-> !sdaOe && !req; endproperty
    a_reset: assert property (p_reset) else $error("active right after reset");
endmodule // i2csr_monitor

bind i2csr_slave i2csr_monitor #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_mon (
    .clk_sys(clk_sys), .rst_n(rst_n), .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut),
    .sdaOe(sdaOe), .addressSelectPin(addressSelectPin), .regReq(regReq),
    .regRdData(regRdData));

// >>> verif/i2csr_master.sv
// Bus master model making the serial clock and sharing the data line
`timescale 1ns/100ps
module i2csr_master (
    output logic sclClk,
    output logic drvLow,
    input wire logic sdaWire
);
    logic bClk;

    // 30 ns base tick, offset so it keeps no phase with the system clock
    initial begin
        bClk = 1'b0;
        sclClk = 1'b1;
        drvLow = 1'b0;
        #7;
        forever #15 bClk = ~bClk;
    end

    task automatic ticks(input int n);
        repeat (n) @(posedge bClk);
    endtask

    // One clock pulse; half periods of 150 ns keep the port's timing limits
    task automatic pulse(output logic b);
        ticks(5);
        sclClk <= 1'b1;
        ticks(3);
        b = sdaWire;
        ticks(2);
        sclClk <= 1'b0;
    endtask

    task automatic sendBit(input logic v);
        logic d;
        ticks(1);
        drvLow <= ~v;
        pulse(d);
    endtask

    task automatic letGo();
        ticks(1);
        drvLow <= 1'b0;
    endtask

    // Data falls while the clock is high
    task automatic start();
        letGo();
        ticks(3);
        sclClk <= 1'b1;
        ticks(5);
        drvLow <= 1'b1;
        ticks(5);
        sclClk <= 1'b0;
    endtask

    task automatic stop();
        ticks(1);
        drvLow <= 1'b1;
        ticks(3);
        sclClk <= 1'b1;
        ticks(5);
        drvLow <= 1'b0;
        ticks(5);
    endtask

    task automatic wrByte(input logic [7:0] b, output logic ack);
        for (int i = 7; i >= 0; i--) begin
            sendBit(b[i]);
        end
        letGo();
        pulse(ack);
    endtask

    // Last byte answered with a released line, others pulled low
    task automatic rdByte(input logic last, output logic [7:0] b);
        letGo();
        for (int i = 7; i >= 0; i--) begin
            pulse(b[i]);
        end
        sendBit(last);
    endtask
endmodule // i2csr_master

// >>> verif/i2csr_slave_test.sv
// Self-checking bench for the two-wire register slave port
`timescale 1ns/100ps
module i2csr_slave_test;
    logic clk_sys, rst_n, sclClk, drvLow, sdaIn, sdaOut, sdaOe, addressSelectPin, ack;
    i2csr_pkg::i2csr_regreq_s regReq;
    logic [7:0] regRdData, ptr, rb;
    logic [7:0] mem [256];
    logic [7:0] d [3];
    logic [15:0] expWr[$];
    logic [7:0] expRd[$];
    int n_errors, checked, cycles, seed;

    initial begin
        clk_sys = 1'b0;
        forever #4 clk_sys = ~clk_sys;
    end

    // Open-drain wire with pull-up
    assign sdaIn = ~(sdaOe | drvLow);

    i2csr_slave #(.TIMEOUT_CYCLES(200)) DUT (.clk_sys(clk_sys), .rst_n(rst_n),
        .sclClk(sclClk), .sdaIn(sdaIn), .sdaOut(sdaOut), .sdaOe(sdaOe),
        .addressSelectPin(addressSelectPin), .regReq(regReq), .regRdData(regRdData));
    i2csr_master m (.sclClk(sclClk), .drvLow(drvLow), .sdaWire(sdaIn));

    task automatic check(string name, logic [15:0] seen, logic [15:0] exp);
        checked++;
        if (seen !== exp) begin
            n_errors++;
            $display("[ERR] %s expected %h seen %h", name, exp, seen);
        end
    endtask

    task automatic end_sim();
        $display("Checks %0d, errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("All tests passed");
        end else begin
            $display("Some tests failed");
        end
        $finish;
    endtask

    // Read data is set up at the falling edge while the strobe stands,
    // so the port captures it on the very next rising edge
    always @(negedge clk_sys) begin
        regRdData <= mem[regReq.addr];
    end

    // Register file and scoreboard
    always @(posedge clk_sys) begin
        cycles++;
        if (regReq.wrEn === 1'b1) begin
            mem[regReq.addr] <= regReq.wrData;
            check("write", {regReq.addr, regReq.wrData},
                expWr.size() ? expWr.pop_front() : 16'hxxxx);
        end
        if (regReq.rdEn === 1'b1) begin
            check("fetch", {8'h00, regReq.addr},
                expRd.size() ? {8'h00, expRd.pop_front()} : 16'hxxxx);
        end
        if (cycles == 40000) begin
            n_errors++;
            end_sim();
        end
    end

    initial begin
        seed = 12089;
        rst_n = 1'b0;
        addressSelectPin = 1'b0;
        for (int i = 0; i < 256; i++) begin
            mem[i] = $random(seed);
        end
        ptr = $random(seed);
        for (int i = 0; i < 3; i++) begin
            d[i] = $random(seed);
        end
        repeat (10) @(negedge clk_sys);
        rst_n = 1'b1;
        repeat (5) @(negedge clk_sys);
        // Pointer byte then three data bytes to consecutive places
        m.start();
        m.wrByte(8'hd0, ack);
        check("addr ack", 16'(ack), 16'h0000);
        m.wrByte(ptr, ack);
        check("ptr ack", 16'(ack), 16'h0000);
        for (int i = 0; i < 3; i++) begin
            expWr.push_back({ptr + 8'(i), d[i]});
            m.wrByte(d[i], ack);
            check("data ack", 16'(ack), 16'h0000);
        end
        m.stop();
        // Read on from the kept pointer, no pointer byte
        // A fetch strobes in the acknowledge before its byte, so note it first
        expRd.push_back(ptr + 8'h03);
        expRd.push_back(ptr + 8'h04);
        m.start();
        m.wrByte(8'hd1, ack);
        check("rd addr ack", 16'(ack), 16'h0000);
        for (int i = 3; i < 5; i++) begin
            m.rdByte(i == 4, rb);
            check("rd data", 16'(rb), 16'(mem[ptr + 8'(i)]));
        end
        repeat (30) @(negedge clk_sys);
        check("released", 16'(sdaOe), 16'h0000);
        m.stop();
        // Set the pointer, then read back what was written
        m.start();
        m.wrByte(8'hd0, ack);
        m.wrByte(ptr, ack);
        m.stop();
        for (int i = 0; i < 3; i++) begin
            expRd.push_back(ptr + 8'(i));
        end
        m.start();
        m.wrByte(8'hd1, ack);
        for (int i = 0; i < 3; i++) begin
            m.rdByte(i == 2, rb);
            check("readback", 16'(rb), 16'(d[i]));
        end
        m.stop();
        // Strap level against address low bit, then a wrong fixed part
        for (int i = 0; i < 6; i++) begin
            @(negedge clk_sys);
            addressSelectPin = i[0];
            repeat (8) @(negedge clk_sys);
            m.start();
            m.wrByte({(i < 4) ? 6'h34 : 6'h35, i[1], 1'b0}, ack);
            check("match ack", 16'(ack), 16'(i[1] != i[0] || i >= 4));
            if (ack) begin
                m.wrByte(8'h00, ack);
                check("ignored", 16'(ack), 16'h0001);
            end
            m.stop();
        end
        // Clock held low in the acknowledge slot until the port gives up
        rb = 8'hd2;
        m.start();
        for (int i = 7; i >= 0; i--) begin
            m.sendBit(rb[i]);
        end
        m.letGo();
        repeat (40) @(negedge clk_sys);
        check("ack held", 16'(sdaOe), 16'h0001);
        repeat (200) @(negedge clk_sys);
        check("timeout", 16'(sdaOe), 16'h0000);
        m.start();
        m.wrByte(8'hd2, ack);
        m.wrByte(ptr, ack);
        expWr.push_back({ptr, ~d[0]});
        m.wrByte(~d[0], ack);
        check("after timeout", 16'(ack), 16'h0000);
        m.stop();
        repeat (20) @(negedge clk_sys);
        check("queues", 16'(expWr.size() + expRd.size()), 16'h0000);
        end_sim();
    end
endmodule // i2csr_slave_test
